/* File: hw/isc_defs.svh */
// Constants for the input current sense configuration block.
// Assumes inclusion by bare name from the device, host, checker and bench modules.
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH
`define ISC_CMD_CONFIG      8'hDA
`define ISC_CMD_RANGE       8'hDC
`define ISC_PAGE_A          8'h00
`define ISC_PAGE_B          8'h01
`define ISC_FS_MSB          15
`define ISC_FS_LSB          8
`define ISC_BOOST_BIT       13
`define ISC_OFS_MSB         12
`define ISC_OFS_LSB         8
`define ISC_MAXI_MSB        7
`define ISC_MAXI_LSB        0
`define ISC_RGAIN_MSB       15
`define ISC_RGAIN_LSB       14
`define ISC_FACT_MSB        12
`define ISC_FACT_LSB        0
`define ISC_FS_NOMINAL      8'h32
`define ISC_RGAIN_HALF_MOHM 2'h3
`define ISC_APB_CMD         12'h000
`define ISC_APB_WDATA       12'h004
`define ISC_APB_STATUS      12'h008
`define ISC_APB_RDATA       12'h00C
`define ISC_CTL_GO_BIT      0
`define ISC_CTL_WR_BIT      1
`define ISC_CTL_CODE_LSB    8
`define ISC_CTL_PAGE_LSB    16
`endif

/* File: hw/isc_pkg.sv */
// Types shared by both ends of the configuration link.
// Assumes isc_defs.svh is on the include path.
package isc_pkg;
    typedef enum logic [1:0] {ISC_IDLE, ISC_REQ, ISC_WAIT} isc_state_e;
    typedef logic [15:0] isc_word_t;
endpackage

/* File: hw/isc_if.sv */
// Word-transaction link between host and device.
// Assumes a common clock and reset.
`timescale 1ns/1ns
interface isc_if (
    input wire logic clk
);
    logic        req;
    logic        wr;
    logic [7:0]  page;
    logic [7:0]  code;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    modport host (output req, output wr, output page, output code, output wdata, input ack, input rdata);
    modport dev  (input req, input wr, input page, input code, input wdata, output ack, output rdata);
endinterface

/* File: hw/isc_nvm_field.sv */
// One read-write field whose reset value comes from nonvolatile storage.
// Assumes the default word is stable while reset is held.
`timescale 1ns/1ns
module isc_nvm_field #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Control
    input  wire logic [W-1:0] nvm_val,
    input  wire logic         we,
    input  wire logic [W-1:0] din,
    output      logic [W-1:0] q
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= nvm_val;
        end else if (we) begin
            q <= din;
        end
    end
endmodule

/* File: hw/isc_dev.sv */
// Functional notes
// - Config register accessed by word transactions only.
// - Page 00h channel A, 01h channel B.
// - Shared calibration split across both pages.
// - Page 0 bits 15:8 full-scale, 0.25 A.
// - Page 1 bit 13 boosts analog gain.
// - Page 1 bits 12:8 signed offset code.
// - Bits 7:0 per-channel maximum output current.
// - Full-scale scales current against nominal 50.
// - Host picks gain closest to sense resistance.
// - Host starts offset at zero amperes.
// - Range register meaningful in page 0 only.
// - Range bits 15:14 hold shunt range gain.
// Device end: holds both configuration registers and decodes them for the sense path.
// Assumes the host issues one word request and holds it until ack.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "isc_defs.svh"
module isc_dev
    import isc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Link
    isc_if.dev               lnk,
    // Nonvolatile defaults
    input  wire logic [7:0]  nvm_full_scale,
    input  wire logic        nvm_gain_boost,
    input  wire logic [4:0]  nvm_offset_code,
    input  wire logic [7:0]  nvm_max_out_a,
    input  wire logic [7:0]  nvm_max_out_b,
    input  wire logic [1:0]  nvm_range_gain,
    input  wire logic [12:0] nvm_factory_bits,
    // Decoded settings for the sense path
    output      logic [7:0]  input_full_scale,
    output      logic        input_gain_boost,
    output      logic [4:0]  input_offset_code,
    output      logic [7:0]  max_output_current_a,
    output      logic [7:0]  max_output_current_b,
    output      logic [1:0]  input_range_gain,
    output      logic [3:0]  gain_select,
    output      logic signed [5:0] offset_tenths,
    output      logic        full_scale_nominal,
    output      logic        bad_access
);
    logic        pg_a;
    logic        pg_b;
    logic        is_cfg;
    logic        is_rng;
    logic        take;
    logic        ack_r;
    logic [15:0] rdata_r;
    logic [7:0]  fs_q;
    logic        boost_q;
    logic [4:0]  ofs_q;
    logic [7:0]  maxa_q;
    logic [7:0]  maxb_q;
    logic [1:0]  rg_q;
    logic [12:0] fact_q;
    logic        bad_r;
    logic [3:0]  gsel_r;
    logic signed [5:0] ofs_r;
    logic        nom_r;

    assign pg_a   = (lnk.page == `ISC_PAGE_A);
    assign pg_b   = (lnk.page == `ISC_PAGE_B);
    assign is_cfg = (lnk.code == `ISC_CMD_CONFIG);
    assign is_rng = (lnk.code == `ISC_CMD_RANGE);
    assign take   = lnk.req && !ack_r;
    assign lnk.ack   = ack_r;
    assign lnk.rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Stored fields, each reloaded from its nonvolatile default in reset.
    isc_nvm_field #(.W(8)) u_fs (
        .clk     (clk),
        .rst_b   (rst_b),
        .nvm_val (nvm_full_scale),
        .we      (take && lnk.wr && is_cfg && pg_a),
        .din     (lnk.wdata[`ISC_FS_MSB:`ISC_FS_LSB]),
        .q       (fs_q)
    );
    isc_nvm_field #(.W(1)) u_boost (
        .clk     (clk),
        .rst_b   (rst_b),
        .nvm_val (nvm_gain_boost),
        .we      (take && lnk.wr && is_cfg && pg_b),
        .din     (lnk.wdata[`ISC_BOOST_BIT]),
        .q       (boost_q)
    );
    isc_nvm_field #(.W(5)) u_ofs (
        .clk     (clk),
        .rst_b   (rst_b),
        .nvm_val (nvm_offset_code),
        .we      (take && lnk.wr && is_cfg && pg_b),
        .din     (lnk.wdata[`ISC_OFS_MSB:`ISC_OFS_LSB]),
        .q       (ofs_q)
    );
    isc_nvm_field #(.W(8)) u_maxa (
        .clk     (clk),
        .rst_b   (rst_b),
        .nvm_val (nvm_max_out_a),
        .we      (take && lnk.wr && is_cfg && pg_a),
        .din     (lnk.wdata[`ISC_MAXI_MSB:`ISC_MAXI_LSB]),
        .q       (maxa_q)
    );
    isc_nvm_field #(.W(8)) u_maxb (
        .clk     (clk),
        .rst_b   (rst_b),
        .nvm_val (nvm_max_out_b),
        .we      (take && lnk.wr && is_cfg && pg_b),
        .din     (lnk.wdata[`ISC_MAXI_MSB:`ISC_MAXI_LSB]),
        .q       (maxb_q)
    );
    isc_nvm_field #(.W(2)) u_rg (
        .clk     (clk),
        .rst_b   (rst_b),
        .nvm_val (nvm_range_gain),
        .we      (take && lnk.wr && is_rng && pg_a),
        .din     (lnk.wdata[`ISC_RGAIN_MSB:`ISC_RGAIN_LSB]),
        .q       (rg_q)
    );
    isc_nvm_field #(.W(13)) u_fact (
        .clk     (clk),
        .rst_b   (rst_b),
        .nvm_val (nvm_factory_bits),
        .we      (take && lnk.wr && is_rng && pg_a),
        .din     (lnk.wdata[`ISC_FACT_MSB:`ISC_FACT_LSB]),
        .q       (fact_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Word answer: one ack cycle per request, read data captured with it.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
        end else if (take && !lnk.wr) begin
            if (is_cfg && pg_a) begin
                rdata_r <= {fs_q, maxa_q};
            end else if (is_cfg && pg_b) begin
                rdata_r <= {2'h0, boost_q, ofs_q, maxb_q};
            end else if (is_rng && pg_a) begin
                rdata_r <= {rg_q, 1'b0, fact_q};
            end else begin
                rdata_r <= 16'h0000;
            end
        end
    end

    // Any request to another code or page is flagged and otherwise ignored.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bad_r <= 1'b0;
        end else if (take) begin
            bad_r <= !((is_cfg && (pg_a || pg_b)) || (is_rng && pg_a));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded settings for the analog and digital sense path.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gsel_r <= 4'h0;
        end else begin
            gsel_r <= {1'b0, boost_q, rg_q};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ofs_r <= 6'sh00;
        end else begin
            ofs_r <= ofs_q[4] ? $signed({1'b1, ofs_q}) : $signed({1'b0, ofs_q});
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            nom_r <= 1'b0;
        end else begin
            nom_r <= (fs_q == `ISC_FS_NOMINAL);
        end
    end

    // Outputs registered from the stored fields.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            input_full_scale     <= 8'h00;
            input_gain_boost     <= 1'b0;
            input_offset_code    <= 5'h00;
            max_output_current_a <= 8'h00;
            max_output_current_b <= 8'h00;
            input_range_gain     <= 2'h0;
        end else begin
            input_full_scale     <= fs_q;
            input_gain_boost     <= boost_q;
            input_offset_code    <= ofs_q;
            max_output_current_a <= maxa_q;
            max_output_current_b <= maxb_q;
            input_range_gain     <= rg_q;
        end
    end

    assign gain_select        = gsel_r;
    assign offset_tenths      = ofs_r;
    assign full_scale_nominal = nom_r;
    assign bad_access         = bad_r;
endmodule

/* File: hw/isc_host.sv */
// Host end: APB slave registers drive word transactions onto the link.
// Assumes software selects page and code per request.
`timescale 1ns/1ns
`include "isc_defs.svh"
module isc_host
    import isc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Link
    isc_if.host              lnk
);
    isc_state_e  st_r;
    logic [31:0] cmd_r;
    logic [15:0] wd_r;
    logic [15:0] rd_r;
    logic        done_r;
    logic        req_r;
    logic        acc;
    logic        go;

    assign acc = psel && penable;
    assign go  = acc && pwrite && (paddr == `ISC_APB_CMD) && pwdata[`ISC_CTL_GO_BIT] && (st_r == ISC_IDLE);
    assign lnk.req   = req_r;
    assign lnk.wr    = cmd_r[`ISC_CTL_WR_BIT];
    assign lnk.code  = cmd_r[`ISC_CTL_CODE_LSB +: 8];
    assign lnk.page  = cmd_r[`ISC_CTL_PAGE_LSB +: 8];
    assign lnk.wdata = wd_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !pready;
            pslverr <= psel && !pready && !((paddr == `ISC_APB_CMD) || (paddr == `ISC_APB_WDATA)
                       || (paddr == `ISC_APB_STATUS) || (paddr == `ISC_APB_RDATA));
            if (paddr == `ISC_APB_CMD) begin
                prdata <= cmd_r;
            end else if (paddr == `ISC_APB_WDATA) begin
                prdata <= {16'h0000, wd_r};
            end else if (paddr == `ISC_APB_STATUS) begin
                prdata <= {30'h0, done_r, st_r != ISC_IDLE};
            end else if (paddr == `ISC_APB_RDATA) begin
                prdata <= {16'h0000, rd_r};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd_r <= 32'h00000000;
            wd_r  <= 16'h0000;
        end else if (acc && pready && pwrite && st_r == ISC_IDLE) begin
            if (paddr == `ISC_APB_CMD) begin
                cmd_r <= pwdata;
            end else if (paddr == `ISC_APB_WDATA) begin
                wd_r <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r   <= ISC_IDLE;
            req_r  <= 1'b0;
            done_r <= 1'b0;
            rd_r   <= 16'h0000;
        end else begin
            case (st_r)
                ISC_IDLE: begin
                    if (go && pready) begin
                        st_r   <= ISC_REQ;
                        done_r <= 1'b0;
                    end
                end
                ISC_REQ: begin
                    req_r <= 1'b1;
                    st_r  <= ISC_WAIT;
                end
                ISC_WAIT: begin
                    if (lnk.ack) begin
                        req_r  <= 1'b0;
                        rd_r   <= lnk.rdata;
                        done_r <= 1'b1;
                        st_r   <= ISC_IDLE;
                    end
                end
                default: begin
                    st_r <= ISC_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: verification/isc_link_props.sv */
// Concurrent checks on the word link between host and device ends.
// Assumes one clock and the link signals fed in as plain inputs.
`timescale 1ns/1ns
`include "isc_defs.svh"
module isc_link_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Link
    input wire logic        req,
    input wire logic        wr,
    input wire logic [7:0]  page,
    input wire logic [7:0]  code,
    input wire logic [15:0] wdata,
    input wire logic        ack,
    input wire logic [15:0] rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic rd_ack;
    logic known;
    assign rd_ack = ack && !wr;
    assign known  = (code == `ISC_CMD_CONFIG || code == `ISC_CMD_RANGE) && page <= `ISC_PAGE_B;
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_answer: assert property (req && !ack |=> ack) else $error("no ack after request");
    a_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    a_req_held: assert property (req && !ack |=> req && $stable({wr, page, code, wdata}))
        else $error("request changed before ack");
    a_req_drop: assert property (ack |=> !req) else $error("request kept after ack");
    a_ack_cause: assert property (ack |-> $past(req)) else $error("ack without request");
    a_rdata_hold: assert property ($changed(rdata) |-> rd_ack) else $error("read data moved outside a read");
    a_unmapped_zero: assert property (rd_ack && !known |-> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_cfg_b_top: assert property (rd_ack && code == `ISC_CMD_CONFIG && page == `ISC_PAGE_B
        |-> rdata[15:14] == 2'h0) else $error("unused page one bits set");
    a_rng_gap: assert property (rd_ack && code == `ISC_CMD_RANGE && page == `ISC_PAGE_A
        |-> !rdata[13]) else $error("range gap bit set");
    c_read: cover property (rd_ack && known);
    c_write: cover property (ack && wr);
    c_unmapped: cover property (rd_ack && !known);
endmodule

/* File: verification/input_current_sense_config_tb.sv */
// Bench for both link ends: APB drives the host end, the device end holds the settings.
// Assumes the designer's APB register map and a 25 MHz clock.
`timescale 1ns/1ns
`include "isc_defs.svh"
module input_current_sense_config_tb
    import isc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  nv_fs, nv_ma, nv_mb, o_fs, o_ma, o_mb, fs, ma, mb;
    logic [4:0]  nv_ofs, o_ofs, ofs;
    logic [1:0]  nv_rg, o_rg, rg;
    logic [12:0] nv_fac, fac;
    logic [3:0]  o_gs;
    logic [5:0]  o_ot;
    logic        nv_bst, o_bst, o_nom, o_bad, bst, err;
    logic [31:0] rd;
    int          miscompares = 0;
    int          checks = 0;
    always #20 clk = ~clk;
    isc_if i_isc_if (.clk(clk));
    isc_host i_isc_host (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(i_isc_if.host));
    isc_dev i_isc_dev (.clk(clk), .rst_b(rst_b), .lnk(i_isc_if.dev), .nvm_full_scale(nv_fs),
        .nvm_gain_boost(nv_bst), .nvm_offset_code(nv_ofs), .nvm_max_out_a(nv_ma), .nvm_max_out_b(nv_mb),
        .nvm_range_gain(nv_rg), .nvm_factory_bits(nv_fac), .input_full_scale(o_fs), .input_gain_boost(o_bst),
        .input_offset_code(o_ofs), .max_output_current_a(o_ma), .max_output_current_b(o_mb),
        .input_range_gain(o_rg), .gain_select(o_gs), .offset_tenths(o_ot), .full_scale_nominal(o_nom),
        .bad_access(o_bad));
    isc_link_props i_isc_link_props (.clk(clk), .rst_b(rst_b), .req(i_isc_if.req), .wr(i_isc_if.wr),
        .page(i_isc_if.page), .code(i_isc_if.code), .wdata(i_isc_if.wdata), .ack(i_isc_if.ack),
        .rdata(i_isc_if.rdata));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] tenths(input logic [4:0] c);
        return {c[4], c};
    endfunction
    function automatic logic [15:0] cfg_b(input logic b, input logic [4:0] o, input logic [7:0] m);
        return {2'h0, b, o, m};
    endfunction
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        checks++;
        if (got !== ex) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic w, input logic [7:0] pg, input logic [7:0] cd, input logic [15:0] d);
        int n;
        n = 0;
        apb(1'b1, `ISC_APB_WDATA, {16'h0000, d});
        apb(1'b1, `ISC_APB_CMD, {8'h00, pg, cd, 6'h00, w, 1'b1});
        do begin
            apb(1'b0, `ISC_APB_STATUS, 32'h0);
            n++;
        end while (rd[1:0] !== 2'h2 && n < 40);
        chk("link_done", 16'h2, 16'(rd[1:0]));
        apb(1'b0, `ISC_APB_RDATA, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #800000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h6E95));
        {nv_fs, nv_ma, nv_mb, nv_bst, nv_ofs} <= 30'($urandom);
        {nv_rg, nv_fac} <= 15'($urandom);
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        xfer(1'b0, `ISC_PAGE_A, `ISC_CMD_CONFIG, 16'h0000);
        chk("cfg_a_reset", {nv_fs, nv_ma}, rd[15:0]);
        xfer(1'b0, `ISC_PAGE_B, `ISC_CMD_CONFIG, 16'h0000);
        chk("cfg_b_reset", cfg_b(nv_bst, nv_ofs, nv_mb), rd[15:0]);
        xfer(1'b0, `ISC_PAGE_A, `ISC_CMD_RANGE, 16'h0000);
        chk("rng_reset", {nv_rg, 1'b0, nv_fac}, rd[15:0]);
        for (int i = 0; i < 5; i++) begin
            {ma, mb, fac} = 29'($urandom);
            fs = (i == 0) ? 8'h32 : (i == 1) ? 8'hFF : (i == 2) ? 8'h19 : 8'($urandom);
            ofs = (i == 0) ? 5'h00 : (i == 1) ? 5'h10 : (i == 2) ? 5'h0F : 5'($urandom);
            rg = (i == 0) ? `ISC_RGAIN_HALF_MOHM : 2'($urandom);
            bst = (i == 0) ? 1'b0 : (i == 1) ? 1'b1 : 1'($urandom);
            xfer(1'b1, `ISC_PAGE_A, `ISC_CMD_CONFIG, {fs, ma});
            xfer(1'b1, `ISC_PAGE_B, `ISC_CMD_CONFIG, {2'($urandom), bst, ofs, mb});
            xfer(1'b1, `ISC_PAGE_A, `ISC_CMD_RANGE, {rg, 1'($urandom), fac});
            xfer(1'b1, `ISC_PAGE_B, `ISC_CMD_RANGE, 16'($urandom));
            xfer(1'b0, `ISC_PAGE_A, `ISC_CMD_CONFIG, 16'h0000);
            chk("cfg_a", {fs, ma}, rd[15:0]);
            xfer(1'b0, `ISC_PAGE_B, `ISC_CMD_CONFIG, 16'h0000);
            chk("cfg_b", cfg_b(bst, ofs, mb), rd[15:0]);
            xfer(1'b0, `ISC_PAGE_A, `ISC_CMD_RANGE, 16'h0000);
            chk("rng", {rg, 1'b0, fac}, rd[15:0]);
            chk("full_scale", 16'(fs), 16'(o_fs));
            chk("max_a", 16'(ma), 16'(o_ma));
            chk("max_b", 16'(mb), 16'(o_mb));
            chk("boost", 16'(bst), 16'(o_bst));
            chk("ofs_code", 16'(ofs), 16'(o_ofs));
            chk("ofs_tenths", 16'(tenths(ofs)), 16'(o_ot));
            chk("range_gain", 16'(rg), 16'(o_rg));
            chk("gain_sel", 16'({1'b0, bst, rg}), 16'(o_gs));
            chk("nominal", 16'(fs == 8'h32), 16'(o_nom));
        end
        xfer(1'b1, 8'h02, `ISC_CMD_CONFIG, 16'hFFFF);
        xfer(1'b0, 8'h02, `ISC_CMD_CONFIG, 16'h0000);
        chk("bad_page_rd", 16'h0000, rd[15:0]);
        chk("bad_page_flag", 16'h0001, 16'(o_bad));
        xfer(1'b0, `ISC_PAGE_A, 8'hDB, 16'h0000);
        chk("bad_code_flag", 16'h0001, 16'(o_bad));
        xfer(1'b0, `ISC_PAGE_A, `ISC_CMD_CONFIG, 16'h0000);
        chk("cfg_a_kept", {fs, ma}, rd[15:0]);
        chk("good_flag", 16'h0000, 16'(o_bad));
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 16'h0001, 16'(err));
        tally_and_finish;
    end
endmodule
